/* File: rtl/tmc_pkg.sv */
// constants, field layout and enumerations of the timer module
package tmc_pkg;
    // clock rates; the high clock is taken as the system clock
    localparam int SYS_CLOCK_HZ = 20_000_000;
    localparam int SUB_CLOCK_HZ = 32_768;
    localparam int SUB_DIV = SYS_CLOCK_HZ / SUB_CLOCK_HZ;
    localparam logic [9:0] SUB_LAST = 10'(SUB_DIV - 1);
    // register byte offsets
    localparam logic [5:0] OFS_CTRL0 = 6'h00;
    localparam logic [5:0] OFS_CTRL1 = 6'h04;
    localparam logic [5:0] OFS_COUNT_LOW = 6'h08;
    localparam logic [5:0] OFS_COUNT_HIGH = 6'h0c;
    localparam logic [5:0] OFS_CMPA_LOW = 6'h10;
    localparam logic [5:0] OFS_CMPA_HIGH = 6'h14;
    localparam logic [5:0] OFS_CMPP_LOW = 6'h18;
    localparam logic [5:0] OFS_CMPP_HIGH = 6'h1c;
    localparam logic [5:0] OFS_INT_STATUS = 6'h20;
    localparam logic [5:0] OFS_INT_CLEAR = 6'h24;
    localparam logic [5:0] OFS_INT_ENABLE = 6'h28;
    // field positions
    localparam int ON_BIT = 0;
    localparam int PAUSE_BIT = 1;
    localparam int CKSEL_LSB = 2;
    localparam int MODE_LSB = 0;
    localparam int IO_LSB = 2;
    localparam int INIT_BIT = 4;
    localparam int CLRA_BIT = 5;
    localparam int IRQ_A = 0;
    localparam int IRQ_P = 1;
    // implemented bits and reset values
    localparam logic [7:0] CTRL0_MASK = 8'h1f;
    localparam logic [7:0] CTRL1_MASK = 8'h3f;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] CMP_RST = 16'h0000;
    localparam logic [15:0] MASK_16 = 16'hffff;
    localparam logic [15:0] MASK_10 = 16'h03ff;
    typedef enum logic [1:0] {
        KIND_COMPACT = 2'b00,
        KIND_STANDARD = 2'b01,
        KIND_PERIODIC = 2'b10
    } tmc_kind_t;
    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_PULSE = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TIMER = 2'b11
    } tmc_mode_t;
    typedef enum logic [1:0] {
        IO_HOLD = 2'b00,
        IO_LOW = 2'b01,
        IO_HIGH = 2'b10,
        IO_TOGGLE = 2'b11
    } tmc_io_t;
    typedef enum logic [2:0] {
        CK_SYS_DIV4 = 3'b000,
        CK_SYS = 3'b001,
        CK_HIGH_DIV16 = 3'b010,
        CK_HIGH_DIV64 = 3'b011,
        CK_SUB_A = 3'b100,
        CK_SUB_B = 3'b101,
        CK_EXT_RISE = 3'b110,
        CK_EXT_FALL = 3'b111
    } tmc_cksel_t;
endpackage : tmc_pkg

/* File: rtl/tmc_timer.sv */
// timer module: counter, two comparators, output pair, register slave
`timescale 1ns/100ps
// Overview of operation
// [R01] upward counter compared against values A and P
// [R02] compare match flags event, clears, drives output
// [R03] separate interrupt sources for A and P
// [R04] three-bit field selects counter clock source
// [R05] external pin counts rising or falling edges
// [R06] single pulse triggered by pin, not compact
// [R07] second output pin always inverse of first
// [R08] compare mode sets, clears or toggles output
// [R09] PWM waveform appears on the output pair
// [R10] counter 16 bits, periodic kind 10 bits
// [R11] high byte direct, low byte via buffer
// [R12] low compare write fills only the buffer
// [R13] high write stores and copies buffer low
// [R14] high read captures matching low byte
// [R15] low read returns the buffer contents
// [R16] software writes low first, reads high first
// [R17] external pin edges synchronised before counting
module tmc_timer #(
    parameter tmc_pkg::tmc_kind_t TM_KIND = tmc_pkg::KIND_STANDARD
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic extClockPin,
    output logic timerOut,
    output logic timerOutInv,
    output logic irq
);
    import tmc_pkg::*;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    logic [7:0] ctrl0, next_ctrl0, ctrl1, next_ctrl1;
    logic [7:0] holdBuf, next_holdBuf;
    logic [15:0] cmpA, next_cmpA, cmpP, next_cmpP;
    logic [1:0] intStatus, next_intStatus;
    logic [1:0] intEnable, next_intEnable;
    logic ack, next_ack;
    logic [31:0] rdData, next_rdData;
    logic [5:0] presc, next_presc;
    logic [9:0] subCnt, next_subCnt;
    logic extSync1, extSync2, extPrev;
    logic [15:0] cnt, next_cnt;
    logic outLvl, next_outLvl, onPrev, pulseBusy, next_pulseBusy;
    logic req, wrTake, rdFirst, tick, running, hitA, hitP;
    logic extRise, extFall, on, paused, initHigh, clrOnA;
    logic [15:0] cntMask;
    tmc_mode_t mode;
    tmc_io_t io;
    tmc_cksel_t cksel;

    // control field views
    assign on = ctrl0[ON_BIT];
    assign paused = ctrl0[PAUSE_BIT];
    assign cksel = tmc_cksel_t'(ctrl0[CKSEL_LSB +: 3]);
    assign mode = tmc_mode_t'(ctrl1[MODE_LSB +: 2]);
    assign io = tmc_io_t'(ctrl1[IO_LSB +: 2]);
    assign initHigh = ctrl1[INIT_BIT];
    assign clrOnA = ctrl1[CLRA_BIT];
    assign cntMask = (TM_KIND == KIND_PERIODIC) ? MASK_10 : MASK_16; // R10

    // bus handshake: one wait cycle, answer on the second edge
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack;
    assign wrTake = avs_write & ack;
    assign rdFirst = avs_read & ~ack;
    assign avs_readdata = rdData;
    assign irq = |(intStatus & intEnable);

    // register file next values
    always_comb
    begin
        next_ctrl0 = ctrl0;
        next_ctrl1 = ctrl1;
        next_holdBuf = holdBuf;
        next_cmpA = cmpA;
        next_cmpP = cmpP;
        next_intEnable = intEnable;
        next_intStatus = intStatus;
        next_rdData = rdData;
        next_ack = req & ~ack;
        if (rdFirst)
        begin
            case (avs_address)
                OFS_CTRL0: next_rdData = {24'h0, ctrl0};
                OFS_CTRL1: next_rdData = {24'h0, ctrl1};
                OFS_COUNT_HIGH:
                begin
                    next_rdData = {24'h0, cnt[15:8]}; // R11
                    next_holdBuf = cnt[7:0]; // R14
                end
                OFS_CMPA_HIGH:
                begin
                    next_rdData = {24'h0, cmpA[15:8]}; // R11
                    next_holdBuf = cmpA[7:0]; // R14
                end
                OFS_CMPP_HIGH:
                begin
                    next_rdData = {24'h0, cmpP[15:8]}; // R11
                    next_holdBuf = cmpP[7:0]; // R14
                end
                OFS_COUNT_LOW, OFS_CMPA_LOW, OFS_CMPP_LOW:
                    next_rdData = {24'h0, holdBuf}; // R15
                OFS_INT_STATUS: next_rdData = {30'h0, intStatus};
                OFS_INT_ENABLE: next_rdData = {30'h0, intEnable};
                default: next_rdData = 32'h0;
            endcase
        end
        if (wrTake)
        begin
            case (avs_address)
                OFS_CTRL0: next_ctrl0 = avs_writedata[7:0] & CTRL0_MASK;
                OFS_CTRL1: next_ctrl1 = avs_writedata[7:0] & CTRL1_MASK;
                OFS_CMPA_LOW, OFS_CMPP_LOW:
                    next_holdBuf = avs_writedata[7:0]; // R12
                OFS_CMPA_HIGH:
                    next_cmpA = {avs_writedata[7:0], holdBuf}
                        & cntMask; // R13
                OFS_CMPP_HIGH:
                    next_cmpP = {avs_writedata[7:0], holdBuf}
                        & cntMask; // R13
                OFS_INT_CLEAR:
                    next_intStatus = intStatus & ~avs_writedata[1:0];
                OFS_INT_ENABLE: next_intEnable = avs_writedata[1:0];
                default: next_intEnable = intEnable;
            endcase
        end
        // a match in the clearing cycle still sets its bit
        if (hitA)
            next_intStatus[IRQ_A] = 1'b1; // R03
        if (hitP)
            next_intStatus[IRQ_P] = 1'b1; // R03
    end

    // register file storage
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl0 <= CTRL_RST;
            ctrl1 <= CTRL_RST;
            holdBuf <= 8'h00;
            cmpA <= CMP_RST;
            cmpP <= CMP_RST;
            intStatus <= 2'b00;
            intEnable <= 2'b00;
            rdData <= 32'h0;
            ack <= 1'b0;
        end
        else
        begin
            ctrl0 <= next_ctrl0;
            ctrl1 <= next_ctrl1;
            holdBuf <= next_holdBuf;
            cmpA <= next_cmpA;
            cmpP <= next_cmpP;
            intStatus <= next_intStatus;
            intEnable <= next_intEnable;
            rdData <= next_rdData;
            ack <= next_ack;
        end
    end

    // prescaler for divided system/high clock and sub clock
    always_comb
    begin
        next_presc = presc + 6'h01;
        next_subCnt = (subCnt == SUB_LAST) ? 10'h000 : subCnt + 10'h001;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            presc <= 6'h00;
            subCnt <= 10'h000;
        end
        else
        begin
            presc <= next_presc;
            subCnt <= next_subCnt;
        end
    end

    // pin synchroniser; only the second stage feeds edge logic
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            extSync1 <= 1'b0;
            extSync2 <= 1'b0;
            extPrev <= 1'b0;
        end
        else
        begin
            extSync1 <= extClockPin; // R17
            extSync2 <= extSync1; // R17
            extPrev <= extSync2;
        end
    end

    assign extRise = extSync2 & ~extPrev;
    assign extFall = ~extSync2 & extPrev;

    // count clock enable chosen by the select field
    always_comb
    begin
        unique case (cksel)
            CK_SYS_DIV4: tick = (presc[1:0] == 2'b11); // R04
            CK_SYS: tick = 1'b1; // R04
            CK_HIGH_DIV16: tick = (presc[3:0] == 4'hf); // R04
            CK_HIGH_DIV64: tick = (presc == 6'h3f); // R04
            CK_SUB_A, CK_SUB_B: tick = (subCnt == SUB_LAST); // R04
            CK_EXT_RISE: tick = extRise; // R05
            CK_EXT_FALL: tick = extFall; // R05
        endcase
    end

    // comparators watch the counter on every count step
    assign running = on & ~paused & ((mode != MODE_PULSE) | pulseBusy);
    assign hitA = running & tick & (cnt == cmpA); // R01 R02
    assign hitP = running & tick & (cnt == cmpP); // R01 R02

    // counter, output level and single pulse state
    always_comb
    begin
        next_cnt = cnt;
        next_outLvl = outLvl;
        next_pulseBusy = pulseBusy;
        if (on && !onPrev)
        begin
            next_cnt = 16'h0000;
            next_outLvl = initHigh;
            next_pulseBusy = 1'b0;
        end
        else if (mode == MODE_PULSE && TM_KIND != KIND_COMPACT
                 && on && extRise && !pulseBusy)
        begin
            next_pulseBusy = 1'b1; // R06
            next_cnt = 16'h0000;
            next_outLvl = initHigh; // R06
        end
        else if (running && tick)
        begin
            next_cnt = (cnt + 16'h0001) & cntMask; // R01 R10
            if (clrOnA ? hitA : hitP)
                next_cnt = 16'h0000; // R02
            if (mode == MODE_PWM && io == IO_HIGH && hitP)
                next_outLvl = initHigh; // R09
            if (hitA)
            begin
                case (mode)
                    MODE_COMPARE:
                    begin
                        if (io == IO_LOW)
                            next_outLvl = 1'b0; // R08
                        else if (io == IO_HIGH)
                            next_outLvl = 1'b1; // R08
                        else if (io == IO_TOGGLE)
                            next_outLvl = ~outLvl; // R08
                    end
                    MODE_PWM:
                        if (io == IO_HIGH)
                            next_outLvl = ~initHigh; // R09
                    MODE_PULSE:
                    begin
                        next_outLvl = ~initHigh; // R06
                        next_pulseBusy = 1'b0;
                        next_cnt = 16'h0000;
                    end
                    default: next_outLvl = outLvl;
                endcase
            end
        end
        // static PWM levels: forced inactive or active
        if (mode == MODE_PWM && io == IO_HOLD)
            next_outLvl = ~initHigh; // R09
        if (mode == MODE_PWM && io == IO_LOW)
            next_outLvl = initHigh; // R09
        if (TM_KIND == KIND_COMPACT)
            next_pulseBusy = 1'b0; // R06
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt <= 16'h0000;
            outLvl <= 1'b0;
            onPrev <= 1'b0;
            pulseBusy <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            outLvl <= next_outLvl;
            onPrev <= on;
            pulseBusy <= next_pulseBusy;
        end
    end

    // complementary output pair
    assign timerOut = outLvl;
    assign timerOutInv = ~outLvl; // R07

    // bus access sequences
    sequence s_wr(logic [5:0] ofs);
        wrTake && avs_address == ofs;
    endsequence
    sequence s_rd(logic [5:0] ofs);
        rdFirst && avs_address == ofs;
    endsequence

    property p_step;
        running && tick && !hitA && !hitP && !(on && !onPrev)
            |=> cnt == (($past(cnt) + 16'h0001) & cntMask);
    endproperty
    a_step: assert property (p_step) // R01
        else $error("counter did not step by one");

    property p_clear;
        hitP && !clrOnA && mode != MODE_PULSE && !(on && !onPrev)
            |=> cnt == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) // R02
        else $error("period match did not clear counter");

    property p_irq;
        hitA ##1 1'b1 |-> intStatus[IRQ_A] ##1 intStatus[IRQ_A]
            || $past(wrTake);
    endproperty
    a_irq: assert property (p_irq) // R03
        else $error("match A flag not raised");

    property p_irqp;
        hitP |=> intStatus[IRQ_P] && (irq == intEnable[IRQ_P]
            || intStatus[IRQ_A]);
    endproperty
    a_irqp: assert property (p_irqp) // R03
        else $error("match P flag or interrupt wrong");

    property p_sys;
        cksel == CK_SYS_DIV4 && tick
            |=> (!tick || cksel != CK_SYS_DIV4) [*3];
    endproperty
    a_sys: assert property (p_sys) // R04
        else $error("divided system clock ticks too often");

    // a counted pin rise must be three clocks old at the pin
    property p_ext;
        cksel == CK_EXT_RISE && tick |-> $past(extClockPin, 2)
            && !$past(extClockPin, 3);
    endproperty
    a_ext: assert property (p_ext) // R05 R17
        else $error("external count without synchronised rise");

    property p_pulse;
        mode == MODE_PULSE && on && onPrev && extRise && !pulseBusy
            && TM_KIND != KIND_COMPACT |=> pulseBusy
            && cnt == 16'h0000 && timerOut == $past(initHigh);
    endproperty
    a_pulse: assert property (p_pulse) // R06
        else $error("pin rise did not start single pulse");

    property p_inv;
        timerOutInv == ~timerOut;
    endproperty
    a_inv: assert property (p_inv) // R07
        else $error("inverted output not complementary");

    property p_toggle;
        mode == MODE_COMPARE && io == IO_TOGGLE && hitA
            && !(on && !onPrev) |=> timerOut != $past(timerOut);
    endproperty
    a_toggle: assert property (p_toggle) // R08
        else $error("toggle on match A missing");

    property p_pwm;
        mode == MODE_PWM && io == IO_HIGH && hitA && !hitP
            && !(on && !onPrev) |=> timerOut == !initHigh;
    endproperty
    a_pwm: assert property (p_pwm) // R09
        else $error("PWM duty edge wrong");

    property p_width;
        (cnt & ~cntMask) == 16'h0000;
    endproperty
    a_width: assert property (p_width) // R10
        else $error("counter exceeds its width");

    property p_lowwr;
        s_wr(OFS_CMPA_LOW) |=> cmpA == $past(cmpA)
            && holdBuf == $past(avs_writedata[7:0]);
    endproperty
    a_lowwr: assert property (p_lowwr) // R12
        else $error("low write touched compare value");

    property p_highwr;
        s_wr(OFS_CMPA_HIGH) |=> cmpA == ({$past(avs_writedata[7:0]),
            $past(holdBuf)} & cntMask);
    endproperty
    a_highwr: assert property (p_highwr) // R13
        else $error("high write did not merge buffer");

    property p_highrd;
        s_rd(OFS_COUNT_HIGH) |=> holdBuf == $past(cnt[7:0])
            && avs_readdata[7:0] == $past(cnt[15:8]);
    endproperty
    a_highrd: assert property (p_highrd) // R11 R14
        else $error("high read did not capture low byte");

    property p_lowrd;
        s_rd(OFS_CMPA_LOW) |=> avs_readdata == {24'h0, $past(holdBuf)}
            && !avs_waitrequest;
    endproperty
    a_lowrd: assert property (p_lowrd) // R15
        else $error("low read not from buffer");
endmodule : tmc_timer

/* File: dv/tmc_pin_model.sv */
// far side model: external count pin source and load on the output pair
`timescale 1ns/100ps
module tmc_pin_model (
    input wire logic clk,
    input wire logic timerOut,
    input wire logic timerOutInv,
    output logic extClockPin
);
    int toggles;
    int invToggles;

    // pin starts low, counters start empty
    initial
    begin
        extClockPin = 1'b0;
        toggles = 0;
        invToggles = 0;
    end

    // load on the output pins: counts every level change seen
    always @(timerOut)
    begin
        toggles++;
    end

    always @(timerOutInv)
    begin
        invToggles++;
    end

    // n level changes, each level held three clocks, past the sync depth
    task automatic edges(input int n);
        repeat (n)
        begin
            @(posedge clk);
            extClockPin <= ~extClockPin;
            repeat (2) @(posedge clk);
        end
    endtask : edges
endmodule : tmc_pin_model

/* File: dv/test_timer_module_common.sv */
// self-checking bench of the timer through its register bus and pins
`timescale 1ns/100ps
module test_timer_module_common;
    import tmc_pkg::*;
    typedef struct packed {logic wr; logic [5:0] a;
        logic [7:0] d; logic [7:0] e;} tmc_row_t;
    logic clk;
    logic arst_n;
    logic [5:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic extClockPin;
    logic timerOut;
    logic timerOutInv;
    logic irq;
    logic [31:0] q;
    int nMismatch = 0;
    int compares = 0;
    int cycles = 0;
    int i;
    int t0;
    int u0;
    int hi;
    // register accesses: write, or read and expect
    tmc_row_t rows [0:25] = '{
        '{1'b0, OFS_CTRL0, 8'h00, 8'h00},
        '{1'b0, OFS_CTRL1, 8'h00, 8'h00},
        '{1'b1, OFS_CTRL1, 8'h3f, 8'h00},
        '{1'b0, OFS_CTRL1, 8'h00, 8'h3f},
        '{1'b1, OFS_CTRL0, 8'hff, 8'h00},
        '{1'b0, OFS_CTRL0, 8'h00, 8'h1f},
        '{1'b1, OFS_CTRL0, 8'h00, 8'h00},
        '{1'b1, OFS_CMPA_LOW, 8'h34, 8'h00},
        '{1'b1, OFS_CMPA_HIGH, 8'h12, 8'h00},
        '{1'b0, OFS_CMPA_HIGH, 8'h00, 8'h12},
        '{1'b0, OFS_CMPA_LOW, 8'h00, 8'h34},
        '{1'b1, OFS_CMPA_LOW, 8'h56, 8'h00},
        '{1'b0, OFS_CMPA_HIGH, 8'h00, 8'h12},
        '{1'b0, OFS_CMPA_LOW, 8'h00, 8'h34},
        '{1'b1, OFS_CMPP_LOW, 8'hcd, 8'h00},
        '{1'b1, OFS_CMPP_HIGH, 8'hab, 8'h00},
        '{1'b0, OFS_CMPP_HIGH, 8'h00, 8'hab},
        '{1'b0, OFS_CMPP_LOW, 8'h00, 8'hcd},
        '{1'b1, OFS_COUNT_HIGH, 8'h55, 8'h00},
        '{1'b0, OFS_COUNT_HIGH, 8'h00, 8'h00},
        '{1'b0, OFS_COUNT_LOW, 8'h00, 8'h00},
        '{1'b1, 6'h2c, 8'h77, 8'h00},
        '{1'b0, 6'h2c, 8'h00, 8'h00},
        '{1'b0, OFS_INT_STATUS, 8'h00, 8'h00},
        '{1'b1, OFS_INT_ENABLE, 8'h03, 8'h00},
        '{1'b0, OFS_INT_ENABLE, 8'h00, 8'h03}
    };
    // forced levels: bit 8 expected pin, bits 7..0 control 1
    logic [8:0] frc [0:5] = '{9'h020, 9'h130, 9'h034, 9'h128,
        9'h012, 9'h116};

    tmc_timer #(.TM_KIND(KIND_STANDARD)) i_dut (
        .clk(clk),
        .arst_n(arst_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .extClockPin(extClockPin),
        .timerOut(timerOut),
        .timerOutInv(timerOutInv),
        .irq(irq)
    );

    tmc_pin_model i_pin (
        .clk(clk),
        .timerOut(timerOut),
        .timerOutInv(timerOutInv),
        .extClockPin(extClockPin)
    );

    // 20 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chkReg(input string nm, input logic [31:0] exp,
        input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chkReg

    task automatic chkBit(input string nm, input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("MISMATCH %s expected %b seen %b", nm, exp, got);
        end
    endtask : chkBit

    // one bus cycle, held until waitrequest is sampled low at a rise
    task automatic bus(input logic wr, input logic [5:0] a,
        input logic [7:0] d, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 50)
        begin
            n++;
            @(posedge clk);
        end
        if (n == 50)
        begin
            nMismatch++;
            $display("MISMATCH waitrequest expected 0 seen 1");
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask : wr

    task automatic rdChk(input string nm, input logic [5:0] a,
        input logic [7:0] e);
        logic [31:0] v;
        bus(1'b0, a, 8'h00, v);
        chkReg(nm, {24'h0, e}, v);
    endtask : rdChk

    task automatic irqChk(input logic e);
        @(negedge clk);
        chkBit("irq", e, irq);
    endtask : irqChk

    task end_sim;
        $display("compares %0d mismatches %0d", compares, nMismatch);
        if (nMismatch == 0 && compares > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    // output pair stays complementary at all times
    always @(negedge clk)
    begin
        if (arst_n === 1'b1)
        begin
            chkBit("inverted pin", ~timerOut, timerOutInv);
        end
    end

    // hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            nMismatch++;
            end_sim();
        end
    end

    // main sequence
    initial
    begin
        arst_n = 1'b0;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (5) @(negedge clk);
        chkBit("out in reset", 1'b0, timerOut);
        chkBit("irq in reset", 1'b0, irq);
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        for (i = 0; i < 26; i++)
        begin
            bus(rows[i].wr, rows[i].a, rows[i].d, q);
            if (rows[i].wr === 1'b0)
            begin
                chkReg($sformatf("reg %0h", rows[i].a), rows[i].e, q);
            end
        end
        // compare mode toggling on A, counter cleared by A
        wr(OFS_CMPA_LOW, 8'h04);
        wr(OFS_CMPA_HIGH, 8'h00);
        wr(OFS_CTRL1, 8'h2c);
        wr(OFS_CTRL0, 8'h05);
        hi = 0;
        while (irq !== 1'b1 && hi < 30)
        begin
            hi++;
            @(negedge clk);
        end
        chkBit("irq on A", 1'b1, irq);
        @(negedge clk);
        t0 = i_pin.toggles;
        u0 = i_pin.invToggles;
        repeat (50) @(negedge clk);
        chkReg("toggles", 32'(i_pin.toggles - t0), 32'h0a);
        chkReg("inv toggles", 32'(i_pin.invToggles - u0), 32'h0a);
        wr(OFS_CTRL0, 8'h00);
        rdChk("status A", OFS_INT_STATUS, 8'h01);
        wr(OFS_INT_ENABLE, 8'h02);
        irqChk(1'b0);
        wr(OFS_INT_ENABLE, 8'h01);
        irqChk(1'b1);
        wr(OFS_INT_CLEAR, 8'h01);
        irqChk(1'b0);
        rdChk("status cleared", OFS_INT_STATUS, 8'h00);
        // hold, force high or low on A match, then static PWM levels
        for (i = 0; i < 6; i++)
        begin
            wr(OFS_CTRL0, 8'h00);
            wr(OFS_CTRL1, frc[i][7:0]);
            wr(OFS_CTRL0, 8'h05);
            repeat (30) @(negedge clk);
            chkBit("forced level", frc[i][8], timerOut);
        end
        // PWM: period 10 ticks, active from P match to A match
        wr(OFS_CTRL0, 8'h00);
        wr(OFS_INT_CLEAR, 8'h03);
        wr(OFS_CMPA_LOW, 8'h03);
        wr(OFS_CMPA_HIGH, 8'h00);
        wr(OFS_CMPP_LOW, 8'h09);
        wr(OFS_CMPP_HIGH, 8'h00);
        wr(OFS_CTRL1, 8'h1a);
        wr(OFS_CTRL0, 8'h05);
        repeat (20) @(negedge clk);
        hi = 0;
        repeat (100)
        begin
            @(negedge clk);
            if (timerOut === 1'b1)
            begin
                hi++;
            end
        end
        chkReg("pwm high cycles", 32'(hi), 32'h28);
        wr(OFS_CTRL0, 8'h00);
        rdChk("status A and P", OFS_INT_STATUS, 8'h03);
        // event counting on pin rising, then on pin falling edges
        wr(OFS_CMPP_LOW, 8'hff);
        wr(OFS_CMPP_HIGH, 8'hff);
        wr(OFS_CTRL1, 8'h03);
        wr(OFS_CTRL0, 8'h19);
        i_pin.edges(5);
        repeat (6) @(negedge clk);
        rdChk("count high", OFS_COUNT_HIGH, 8'h00);
        rdChk("count low", OFS_COUNT_LOW, 8'h03);
        wr(OFS_CTRL0, 8'h00);
        wr(OFS_CTRL0, 8'h1d);
        i_pin.edges(3);
        repeat (6) @(negedge clk);
        rdChk("count high", OFS_COUNT_HIGH, 8'h00);
        rdChk("count low", OFS_COUNT_LOW, 8'h02);
        // divide by four: 40 counted cycles between start and pause
        wr(OFS_CTRL0, 8'h00);
        wr(OFS_CTRL0, 8'h01);
        repeat (39) @(negedge clk);
        wr(OFS_CTRL0, 8'h03);
        rdChk("div4 high", OFS_COUNT_HIGH, 8'h00);
        rdChk("div4 low", OFS_COUNT_LOW, 8'h0a);
        // single pulse started by a pin rising edge, ended by A match
        wr(OFS_CTRL0, 8'h00);
        wr(OFS_CMPA_LOW, 8'h08);
        wr(OFS_CMPA_HIGH, 8'h00);
        wr(OFS_CTRL1, 8'h31);
        wr(OFS_CTRL0, 8'h05);
        repeat (20) @(negedge clk);
        chkBit("pulse idle", 1'b1, timerOut);
        i_pin.edges(1);
        repeat (3) @(negedge clk);
        chkBit("pulse active", 1'b1, timerOut);
        repeat (7) @(negedge clk);
        chkBit("pulse held", 1'b1, timerOut);
        @(negedge clk);
        chkBit("pulse ended", 1'b0, timerOut);
        // mid-run reset clears control, flags and interrupt
        @(posedge clk);
        arst_n <= 1'b0;
        @(negedge clk);
        chkBit("out after reset", 1'b0, timerOut);
        chkBit("irq after reset", 1'b0, irq);
        @(posedge clk);
        arst_n <= 1'b1;
        rdChk("ctrl after reset", OFS_CTRL1, 8'h00);
        rdChk("status after reset", OFS_INT_STATUS, 8'h00);
        end_sim();
    end
endmodule : test_timer_module_common
